// ===== common/ssnc_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef SSNC_DEFS_SVH
`define SSNC_DEFS_SVH

`define SSNC_OFF_CTRL      8'h00
`define SSNC_OFF_T_NORM    8'h04
`define SSNC_OFF_T_SAFE    8'h08
`define SSNC_OFF_VLIM      8'h0C
`define SSNC_OFF_DRATE     8'h10
`define SSNC_OFF_STILL     8'h14
`define SSNC_OFF_STATUS    8'h18
`define SSNC_OFF_TIMER     8'h1C
`define SSNC_OFF_IRQ_STAT  8'h20
`define SSNC_OFF_IRQ_CLR   8'h24
`define SSNC_OFF_IRQ_EN    8'h28
`define SSNC_OFF_ACT_VLIM  8'h2C

`define SSNC_CTRL_W        7
`define SSNC_RST_CTRL      7'h00
`define SSNC_RST_T_NORM    16'h03E8
`define SSNC_RST_T_SAFE    16'h01F4
`define SSNC_RST_VLIM      16'h7FFF
`define SSNC_RST_DRATE     16'h0010
`define SSNC_RST_STILL     16'h0008

`define SSNC_IRQ_TIMEOUT   0
`define SSNC_IRQ_DECEL     1
`define SSNC_IRQ_STO       2
`define SSNC_IRQ_DESEL     3
`define SSNC_IRQ_W         4

`define SSNC_CLK_NS        50
`define SSNC_TICK_NS       1000
`define SSNC_TICK_CYC      (`SSNC_TICK_NS / `SSNC_CLK_NS)

`endif

// ===== common/ssnc_pkg.sv
// Types for the stop transition monitor
package ssnc_pkg;

   typedef enum logic [1:0]
   {
      SSNC_TIME_NC,
      SSNC_TREND,
      SSNC_ACTUAL,
      SSNC_STILL_PRIO
   } ssnc_variant_t;

   typedef enum logic [1:0]
   {
      SSNC_IDLE,
      SSNC_DECEL,
      SSNC_STO
   } ssnc_state_t;

   typedef struct packed
   {
      logic          poslim_en;
      logic          drive_ctrl;
      logic          from_normal;
      ssnc_variant_t variant;
      logic          unused;
      logic          stop_select;
   } ssnc_ctrl_t;

   typedef struct packed
   {
      logic [15:0] act_vel;
      logic [15:0] trend_vel;
      logic [15:0] vel_cmd;
   } ssnc_motion_t;

endpackage

// ===== core/ssnc_monitor.sv
// Stop transition monitor with AXI4-Lite register slave
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "ssnc_defs.svh"

module ssnc_monitor
   import ssnc_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          reset_n,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire ssnc_motion_t  motion,
   input  wire logic          drive_enable,
   input  wire logic          safety_error,
   output logic [15:0]        vel_cmd_limited,
   output logic               sto_active,
   output logic               transition_timeout_fatal_error,
   output logic               decel_exceeded_error,
   output logic               irq
);

   function automatic logic [15:0] mag(input logic [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction

   ssnc_ctrl_t                 ctrl_q;
   logic [15:0]                t_norm_q, t_safe_q, vlim_q, drate_q, still_q;
   logic [`SSNC_IRQ_W-1:0]     irq_stat_q, irq_en_q, irq_set;
   ssnc_state_t                state_q;
   logic                       sel_q;
   logic [15:0]                timer_q;
   logic [4:0]                 tick_cnt_q;
   logic                       tick;
   logic [15:0]                ramp_q;
   logic [15:0]                act_limit;
   logic                       mon_on, overspeed, still, sel_edge;
   logic                       expire, done, desel, err_end;
   logic                       aw_q, w_q;
   logic [7:0]                 awaddr_q;
   logic [31:0]                wdata_q;
   logic [3:0]                 wstrb_q;
   logic                       wr_go;
   logic [31:0]                rd_val;

   // Write path: address and data taken in either order
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign wr_go         = aw_q && w_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_rresp   = 2'b00;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] be);
      merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   // Configuration registers
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_q   <= ssnc_ctrl_t'(`SSNC_RST_CTRL);
         t_norm_q <= `SSNC_RST_T_NORM;
         t_safe_q <= `SSNC_RST_T_SAFE;
         vlim_q   <= `SSNC_RST_VLIM;
         drate_q  <= `SSNC_RST_DRATE;
         still_q  <= `SSNC_RST_STILL;
         irq_en_q <= '0;
      end
      else if (wr_go)
      begin
         case (awaddr_q)
            `SSNC_OFF_CTRL:
               if (wstrb_q[0])
                  ctrl_q <= ssnc_ctrl_t'(wdata_q[`SSNC_CTRL_W-1:0]);
            `SSNC_OFF_T_NORM: t_norm_q <= merge16(t_norm_q, wdata_q, wstrb_q);
            `SSNC_OFF_T_SAFE: t_safe_q <= merge16(t_safe_q, wdata_q, wstrb_q);
            `SSNC_OFF_VLIM:   vlim_q   <= merge16(vlim_q, wdata_q, wstrb_q);
            `SSNC_OFF_DRATE:  drate_q  <= merge16(drate_q, wdata_q, wstrb_q);
            `SSNC_OFF_STILL:  still_q  <= merge16(still_q, wdata_q, wstrb_q);
            `SSNC_OFF_IRQ_EN:
               if (wstrb_q[0])
                  irq_en_q <= wdata_q[`SSNC_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Tick prescaler for the transition timer
   assign tick = (tick_cnt_q == 5'(`SSNC_TICK_CYC - 1));

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         tick_cnt_q <= 5'd0;
      else if (tick || state_q != SSNC_DECEL)
         tick_cnt_q <= 5'd0;
      else
         tick_cnt_q <= tick_cnt_q + 5'd1;
   end

   // Transition conditions
   assign sel_edge  = ctrl_q.stop_select && !sel_q;
   assign mon_on    = ctrl_q.variant != SSNC_TIME_NC;
   assign still     = mag(motion.act_vel) < still_q;
   assign expire    = (timer_q == 16'd0);
   assign done      = still && !drive_enable;
   assign desel     = !ctrl_q.stop_select && !ctrl_q.drive_ctrl;
   assign err_end   = safety_error && ctrl_q.variant == SSNC_STILL_PRIO;
   assign overspeed = mon_on && state_q == SSNC_DECEL &&
                      (ctrl_q.variant == SSNC_TREND ? mag(motion.trend_vel)
                                                    : mag(motion.act_vel))
                      > ramp_q;

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         sel_q <= 1'b0;
      else
         sel_q <= ctrl_q.stop_select;
   end

   // Stop transition sequencer
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         state_q <= SSNC_IDLE;
      else
      begin
         case (state_q)
            SSNC_IDLE:
               if (sel_edge)
                  state_q <= SSNC_DECEL;
            SSNC_DECEL:
               if (expire)
                  state_q <= SSNC_STO;
               else if (err_end)
                  state_q <= SSNC_STO;
               else if (done)
                  state_q <= SSNC_STO;
               else if (desel)
                  state_q <= SSNC_IDLE;
            SSNC_STO:
               if (!ctrl_q.stop_select)
                  state_q <= SSNC_IDLE;
            default: state_q <= SSNC_IDLE;
         endcase
      end
   end

   // Transition timer, untouched by error reactions
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         timer_q <= 16'd0;
      else if (state_q == SSNC_IDLE && sel_edge)
         timer_q <= ctrl_q.from_normal ? t_norm_q : t_safe_q;
      else if (state_q == SSNC_DECEL && tick && !expire)
         timer_q <= timer_q - 16'd1;
   end

   // Deceleration monitor ramp
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         ramp_q <= 16'd0;
      else if (state_q == SSNC_IDLE)
         ramp_q <= vlim_q;
      else if (state_q == SSNC_DECEL && tick)
         ramp_q <= (ramp_q > still_q + drate_q) ? ramp_q - drate_q : still_q;
   end

   assign act_limit = (state_q == SSNC_DECEL && mon_on) ? ramp_q :
                      (state_q == SSNC_STO) ? 16'd0 : vlim_q;

   // Error flags, torque off and limited command
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         transition_timeout_fatal_error <= 1'b0;
         decel_exceeded_error           <= 1'b0;
         sto_active                     <= 1'b0;
         vel_cmd_limited                <= 16'd0;
      end
      else
      begin
         if (state_q == SSNC_DECEL && expire)
            transition_timeout_fatal_error <= 1'b1;
         else if (sel_edge)
            transition_timeout_fatal_error <= 1'b0;
         if (overspeed)
            decel_exceeded_error <= 1'b1;
         else if (sel_edge)
            decel_exceeded_error <= 1'b0;
         sto_active <= (state_q == SSNC_DECEL && (expire || err_end || done)) ||
                       (state_q == SSNC_STO && ctrl_q.stop_select);
         if (ctrl_q.poslim_en && mag(motion.vel_cmd) > act_limit)
            vel_cmd_limited <= motion.vel_cmd[15] ? 16'(-act_limit) : act_limit;
         else
            vel_cmd_limited <= motion.vel_cmd;
      end
   end

   // Sticky interrupt status, set wins over clear
   always_comb
   begin
      irq_set = '0;
      irq_set[`SSNC_IRQ_TIMEOUT] = state_q == SSNC_DECEL && expire;
      irq_set[`SSNC_IRQ_DECEL]   = overspeed;
      irq_set[`SSNC_IRQ_STO]     = state_q == SSNC_DECEL && (expire || err_end || done);
      irq_set[`SSNC_IRQ_DESEL]   = state_q == SSNC_DECEL && !expire && !err_end &&
                                   !done && desel;
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         irq_stat_q <= '0;
      else if (wr_go && awaddr_q == `SSNC_OFF_IRQ_CLR && wstrb_q[0])
         irq_stat_q <= (irq_stat_q & ~wdata_q[`SSNC_IRQ_W-1:0]) | irq_set;
      else
         irq_stat_q <= irq_stat_q | irq_set;
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // Read path
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         `SSNC_OFF_CTRL:     rd_val = {25'd0, ctrl_q};
         `SSNC_OFF_T_NORM:   rd_val = {16'd0, t_norm_q};
         `SSNC_OFF_T_SAFE:   rd_val = {16'd0, t_safe_q};
         `SSNC_OFF_VLIM:     rd_val = {16'd0, vlim_q};
         `SSNC_OFF_DRATE:    rd_val = {16'd0, drate_q};
         `SSNC_OFF_STILL:    rd_val = {16'd0, still_q};
         `SSNC_OFF_STATUS:   rd_val = {26'd0, decel_exceeded_error,
                                       transition_timeout_fatal_error,
                                       sto_active, state_q == SSNC_DECEL, state_q};
         `SSNC_OFF_TIMER:    rd_val = {16'd0, timer_q};
         `SSNC_OFF_IRQ_STAT: rd_val = {28'd0, irq_stat_q};
         `SSNC_OFF_IRQ_EN:   rd_val = {28'd0, irq_en_q};
         `SSNC_OFF_ACT_VLIM: rd_val = {16'd0, act_limit};
         default:            rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule // ssnc_monitor
`default_nettype wire

// ===== testbench/ssnc_monitor_asserts.sv
// Port checker of the stop transition monitor
`timescale 1ns/1ps
`default_nettype none
module ssnc_chk
   import ssnc_pkg::*;
(
   input wire logic         mclk,
   input wire logic         reset_n,
   input wire logic         s_axi_bvalid,
   input wire logic         s_axi_bready,
   input wire ssnc_motion_t motion,
   input wire logic         drive_enable,
   input wire logic         safety_error,
   input wire logic [15:0]  vel_cmd_limited,
   input wire logic         sto_active,
   input wire logic         transition_timeout_fatal_error,
   input wire logic         decel_exceeded_error
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   property p_to_sto; $rose(transition_timeout_fatal_error) |-> sto_active; endproperty
   a_to_sto: assert property (p_to_sto) else $error("timeout without torque off");
   property p_to_keep; transition_timeout_fatal_error && sto_active |=> transition_timeout_fatal_error; endproperty
   a_to_keep: assert property (p_to_keep) else $error("timeout error lost");
   property p_de_keep; decel_exceeded_error && sto_active |=> decel_exceeded_error; endproperty
   a_de_keep: assert property (p_de_keep) else $error("decel error lost");
   property p_de_rise; $rose(decel_exceeded_error) |-> !$past(sto_active); endproperty
   a_de_rise: assert property (p_de_rise) else $error("decel error outside deceleration");
   property p_sto_why;
      $rose(sto_active) |-> transition_timeout_fatal_error || !$past(drive_enable) || $past(safety_error);
   endproperty
   a_sto_why: assert property (p_sto_why) else $error("torque off without cause");
   // A drive-controlled run deselected earlier drops torque off after one cycle
   property p_sto_end;
      $fell(sto_active) |-> s_axi_bvalid || $past(s_axi_bvalid) || !$past(sto_active, 2);
   endproperty
   a_sto_end: assert property (p_sto_end) else $error("torque off left without write");
   property p_clamp;
      vel_cmd_limited == 16'h0000 || (vel_cmd_limited[15] == $past(motion.vel_cmd[15]) && (vel_cmd_limited[15]
         ? $signed(vel_cmd_limited) >= $signed($past(motion.vel_cmd))
         : $signed(vel_cmd_limited) <= $signed($past(motion.vel_cmd))));
   endproperty
   a_clamp: assert property (p_clamp) else $error("limited command exceeds command");
   property p_b_once; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_once: assert property (p_b_once) else $error("write response repeated");
endmodule // ssnc_chk
bind ssnc_monitor ssnc_chk i_ssnc_chk (.mclk(mclk), .reset_n(reset_n), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .motion(motion), .drive_enable(drive_enable), .safety_error(safety_error),
   .vel_cmd_limited(vel_cmd_limited), .sto_active(sto_active),
   .transition_timeout_fatal_error(transition_timeout_fatal_error), .decel_exceeded_error(decel_exceeded_error));
`default_nettype wire

// ===== testbench/ssnc_nc_model.sv
// Motion controller model ramping the axis down by command
`timescale 1ns/1ps
`default_nettype none
module ssnc_nc_model
   import ssnc_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic         go,
   input  wire logic [15:0]  vel0,
   input  wire logic [15:0]  rate,
   output var ssnc_motion_t  motion,
   output logic              drive_enable
);
   logic [15:0] vel_q;
   // Ramp by rate, drop enable at zero; rate 0 never stops a positive velocity
   always_ff @(posedge mclk or negedge reset_n)
      if (!reset_n)
      begin
         vel_q <= 16'h0000;
         drive_enable <= 1'b0;
      end
      else if (!go)
      begin
         vel_q <= vel0;
         drive_enable <= 1'b1;
      end
      else if ($signed(vel_q) > $signed(rate))
         vel_q <= vel_q - rate;
      else
      begin
         vel_q <= 16'h0000;
         drive_enable <= 1'b0;
      end
   assign motion = '{act_vel: vel_q, trend_vel: vel_q, vel_cmd: vel_q};
endmodule // ssnc_nc_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench of the stop transition monitor
`timescale 1ns/1ps
`default_nettype none
`include "ssnc_defs.svh"
module testbench
   import ssnc_pkg::*;
;
   localparam int TK = `SSNC_TICK_CYC;
   logic         mclk = 1'b0, reset_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic         go = 1'b0, serr = 1'b0, awr, wr, bv, arr, rv, de, sto, to_e, de_e, irq;
   logic [7:0]   awa = 8'h00, ara = 8'h00;
   logic [31:0]  wd = 32'h0000_0000, rdat, rd;
   logic [15:0]  v0 = 16'h0064, rate = 16'h0000, vcl;
   logic [1:0]   bre, rre;
   ssnc_motion_t mo;
   int           miscompares = 0, comparisons = 0, cyc = 0, n, nto;
   always #25 mclk = ~mclk;
   ssnc_monitor i_ssnc_monitor (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
      .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .motion(mo), .drive_enable(de), .safety_error(serr), .vel_cmd_limited(vcl), .sto_active(sto),
      .transition_timeout_fatal_error(to_e), .decel_exceeded_error(de_e), .irq(irq));
   ssnc_nc_model i_ssnc_nc_model (.mclk(mclk), .reset_n(reset_n), .go(go), .vel0(v0), .rate(rate),
      .motion(mo), .drive_enable(de));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk)
      if (++cyc == 20000)
      begin
         miscompares++;
         stop_test();
      end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      logic ap, dp;
      @(posedge mclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      ap = 1'b1;
      dp = 1'b1;
      do
      begin
         @(negedge mclk);
         ap = ap && !awr;
         dp = dp && !wr;
         @(posedge mclk);
         awv <= ap;
         wv <= dp;
      end
      while (ap || dp);
      while (!bv) @(negedge mclk);
      check("bresp", bre, 2'b00);
      @(posedge mclk);
      br <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(negedge mclk); while (!arr);
      @(posedge mclk);
      arv <= 1'b0;
      do @(negedge mclk); while (!rv);
      rd = rdat;
      check("rresp", rre, 2'b00);
      @(posedge mclk);
      rr <= 1'b0;
   endtask
   // Select, rewrite control, then wait for torque off
   task automatic start(input logic [31:0] c, input logic [31:0] c2);
      wr_reg(8'h00, c);
      go <= 1'b1;
      wr_reg(8'h00, c2);
      n = 0;
      while (sto !== 1'b1 && n < 2000)
      begin
         @(negedge mclk);
         n++;
      end
   endtask
   task automatic fin;
      wr_reg(8'h00, 32'h0000_0000);
      go <= 1'b0;
      serr <= 1'b0;
      @(negedge mclk);
      check("sto_off", sto, 1'b0);
      @(posedge mclk);
   endtask
   task automatic t_regs;
      logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h28, 8'h2C, 8'h30};
      logic [15:0] ev [12] = '{16'h0000, 16'h03E8, 16'h01F4, 16'h7FFF, 16'h0010, 16'h0008, 16'h0000,
                               16'h0000, 16'h0000, 16'h0000, 16'h7FFF, 16'h0000};
      for (int i = 0; i < 12; i++)
      begin
         rd_reg(ra[i]);
         check("reset_value", rd, ev[i]);
      end
      wr_reg(8'h0C, 32'h0000_0064);
      rd_reg(8'h2C);
      check("act_vlim", rd, 32'h0000_0064);
      $display("test regs done");
   endtask
   task automatic t_timeout;
      wr_reg(8'h08, 32'h0000_0003);
      wr_reg(8'h28, 32'h0000_0001);
      start(32'h0000_0001, 32'h0000_0001);
      nto = n;
      check("sto", sto, 1'b1);
      check("to_err", to_e, 1'b1);
      check("to_time", nto >= 3 * TK - 4 && nto <= 3 * TK, 1'b1);
      rd_reg(8'h20);
      check("irq_stat", rd[0], 1'b1);
      check("irq", irq, 1'b1);
      wr_reg(8'h28, 32'h0000_0000);
      check("irq_mask", irq, 1'b0);
      wr_reg(8'h24, 32'h0000_000F);
      rd_reg(8'h20);
      check("irq_clr", rd[3:0], 4'h0);
      fin();
      $display("test timeout done");
   endtask
   task automatic t_clean;
      wr_reg(8'h04, 32'h0000_0014);
      v0 <= 16'h00C8;
      rate <= 16'h0002;
      start(32'h0000_0011, 32'h0000_0011);
      check("sto", sto, 1'b1);
      check("to_err", to_e, 1'b0);
      rd_reg(8'h1C);
      check("timer_norm", rd > 32'd3 && rd < 32'd20, 1'b1);
      fin();
      rate <= 16'h0000;
      $display("test clean done");
   endtask
   task automatic t_trend;
      v0 <= 16'h03E8;
      start(32'h0000_0005, 32'h0000_0005);
      check("de_err", de_e, 1'b1);
      check("to_err", to_e, 1'b1);
      check("same_time", n + TK >= nto && n <= nto + TK, 1'b1);
      fin();
      $display("test trend done");
   endtask
   task automatic t_actual;
      wr_reg(8'h00, 32'h0000_0048);
      v0 <= 16'hFC18;
      repeat (3) @(negedge mclk);
      check("clamp_neg", vcl, 16'hFF9C);
      @(posedge mclk);
      v0 <= 16'h03E8;
      repeat (3) @(negedge mclk);
      check("clamp_pos", vcl, 16'h0064);
      start(32'h0000_0049, 32'h0000_0049);
      check("de_err", de_e, 1'b1);
      check("to_err", to_e, 1'b1);
      rd_reg(8'h2C);
      check("act_sto", rd, 32'h0000_0000);
      check("clamp_sto", vcl, 16'h0000);
      fin();
      $display("test actual done");
   endtask
   task automatic t_desel;
      v0 <= 16'h0064;
      start(32'h0000_0001, 32'h0000_0000);
      check("desel", sto, 1'b0);
      check("desel_to", to_e, 1'b0);
      rd_reg(8'h20);
      check("irq_desel", rd[3], 1'b1);
      fin();
      $display("test desel done");
   endtask
   task automatic t_drive;
      start(32'h0000_0021, 32'h0000_0020);
      check("drive", sto, 1'b1);
      check("drive_to", to_e, 1'b1);
      fin();
      $display("test drive done");
   endtask
   task automatic t_prio;
      serr <= 1'b1;
      start(32'h0000_000D, 32'h0000_000D);
      check("prio", sto, 1'b1);
      check("prio_to", to_e, 1'b0);
      fin();
      $display("test prio done");
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      t_regs();
      t_timeout();
      t_clean();
      t_trend();
      t_actual();
      t_desel();
      t_drive();
      t_prio();
      stop_test();
   end
endmodule // testbench
`default_nettype wire
